/* File: design/tflop_pkg.sv */
// Purpose: shared constants and types for the toggle flop bank
// Assumes: AXI4-Lite slave with 32-bit data and 4-bit byte addresses
// Notes: offsets are byte addresses of aligned words
package tflop_pkg;

  typedef enum logic [3:0] {
    toggle_flop_async_both,
    toggle_flop_async_both_gated,
    toggle_flop_async_both_loadable,
    toggle_flop_async_one,
    toggle_flop_async_one_gated,
    toggle_flop_async_one_loadable,
    toggle_flop_sync_zero_first,
    toggle_flop_sync_zero_first_loadable,
    toggle_flop_async_zero_gated_load
  } variant_t;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;

  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] DRIVE_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] COUNT_OFFSET = 4'hC;

  localparam int CTRL_VARIANT_LSB = 0;
  localparam int CTRL_INVERT_BIT = 4;
  localparam int CTRL_OLDEST_BIT = 5;
  localparam int CTRL_SRC_BIT = 6;
  localparam int CTRL_W = 7;

  localparam int DRV_TOGGLE_BIT = 0;
  localparam int DRV_CE_BIT = 1;
  localparam int DRV_LOAD_BIT = 2;
  localparam int DRV_DATA_BIT = 3;
  localparam int DRV_SZERO_BIT = 4;
  localparam int DRV_SONE_BIT = 5;
  localparam int DRV_AZERO_BIT = 6;
  localparam int DRV_AONE_BIT = 7;
  localparam int DRV_GLOBAL_BIT = 8;
  localparam int DRIVE_W = 9;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [DRIVE_W-1:0] DRIVE_RESET = 9'h000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/toggle_flop_cell.sv */
// Purpose: one toggle flop whose variant is chosen at run time
// Assumes: controls come from logic on aclk; forcing inputs act without the clock
// Notes: clear beats preset, both beat the clock path
`timescale 1ns/1ps
module toggle_flop_cell
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // variant and controls
  input tflop_pkg::variant_t variant,
  input wire logic toggle_en,
  input wire logic clk_en,
  input wire logic load_en,
  input wire logic load_data,
  input wire logic sync_zero,
  input wire logic sync_one,
  input wire logic async_zero_force,
  input wire logic async_one_force,
  input wire logic global_active,
  input wire logic power_on_pulse_net,
  // state
  output logic async_low,
  output logic async_high,
  output logic q
);

  logic q_q;
  logic q_d;
  wire has_clear = variant inside {tflop_pkg::toggle_flop_async_both, tflop_pkg::toggle_flop_async_both_gated,
    tflop_pkg::toggle_flop_async_both_loadable, tflop_pkg::toggle_flop_async_zero_gated_load};
  wire has_preset = variant inside {tflop_pkg::toggle_flop_async_both, tflop_pkg::toggle_flop_async_both_gated,
    tflop_pkg::toggle_flop_async_both_loadable, tflop_pkg::toggle_flop_async_one,
    tflop_pkg::toggle_flop_async_one_gated, tflop_pkg::toggle_flop_async_one_loadable};
  wire preset_type = variant inside {tflop_pkg::toggle_flop_async_one, tflop_pkg::toggle_flop_async_one_gated,
    tflop_pkg::toggle_flop_async_one_loadable};
  wire is_sync = variant inside {tflop_pkg::toggle_flop_sync_zero_first,
    tflop_pkg::toggle_flop_sync_zero_first_loadable};
  wire has_ce = !(variant inside {tflop_pkg::toggle_flop_async_both, tflop_pkg::toggle_flop_async_one});
  wire load_free = variant inside {tflop_pkg::toggle_flop_async_both_loadable,
    tflop_pkg::toggle_flop_async_one_loadable, tflop_pkg::toggle_flop_sync_zero_first_loadable};
  wire load_gated = (variant == tflop_pkg::toggle_flop_async_zero_gated_load);
  wire ce_eff = clk_en | ~has_ce;
  wire load_any = load_en & (load_free | load_gated);

  // forcing terms, clear side first
  assign async_low = (has_clear & async_zero_force)
    | (global_active & ~preset_type)
    | power_on_pulse_net;
  assign async_high = (has_preset & async_one_force)
    | (global_active & preset_type);

  wire zero_hit = is_sync & sync_zero;
  wire one_hit = is_sync & ~sync_zero & sync_one;
  wire load_hit = (load_free & load_en)
    | (load_gated & load_en & clk_en);
  wire toggle_hit = toggle_en & ce_eff & ~load_any;

  assign q_d = zero_hit ? 1'b0 :
               one_hit ? 1'b1 :
               load_hit ? load_data :
               toggle_hit ? ~q_q : q_q;

  always_ff @(posedge aclk or posedge async_low or posedge async_high)
  begin
    if (async_low)
      q_q <= 1'b0;
    else if (async_high)
      q_q <= 1'b1;
    else if (!aresetn)
      q_q <= 1'b0;
    else
      q_q <= q_d;
  end

  assign q = q_q;

endmodule

/* File: design/toggle_flop_bank.sv */
// Purpose: toggle flop with selectable variant, steered by pins or AXI4-Lite registers
// Assumes: control pins come from logic on aclk; forcing and global nets are asynchronous
// Notes: Operation rules below
// Operation
// - Clear input high forces output low at once, regardless of clock.
// - Preset input high forces output high at once, regardless of clock.
// - Output inverts on edge with toggle, nothing stronger active; enable high too except in toggle_flop_async_both and toggle_flop_async_one.
// - Enable low with nothing stronger active: output holds across edges; the two ungated variants still toggle on edges with toggle high.
// - Loadable clear/preset variant: load captures data regardless of enable.
// - Gated-load clear variant: load captures data only with enable high.
// - Loadable preset variant: load overrides enable and captures data.
// - Synchronous reset high drives output low on the edge, overriding all.
// - Synchronous reset and set both high: reset wins, output low.
// - Set high, reset low: output goes high on edge even with enable low.
// - Synchronous loadable: load overrides enable when reset and set are low.
// - Preset-type variants go high while the global net is active.
// - Clear and synchronous variants clear low at power-up and on global net.
// - Oldest family mode treats the global net as active low.
`timescale 1ns/1ps
module toggle_flop_bank
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [tflop_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [tflop_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [tflop_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [tflop_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // user logic controls
  input wire logic toggle_en,
  input wire logic clk_en,
  input wire logic load_en,
  input wire logic load_data,
  input wire logic sync_zero,
  input wire logic sync_one,
  input wire logic async_zero_force,
  input wire logic async_one_force,
  // global nets
  input wire logic global_reset_net,
  input wire logic global_set_clear_net,
  input wire logic power_on_pulse_net,
  // flop output
  output logic flop_q
);

  // register state
  logic [tflop_pkg::CTRL_W-1:0] ctrl_q;
  logic [tflop_pkg::DRIVE_W-1:0] drive_q;
  logic [tflop_pkg::COUNT_W-1:0] count_q;
  logic [tflop_pkg::COUNT_W-1:0] count_d;
  logic q_seen_q;
  logic aw_full_q;
  logic w_full_q;
  logic [tflop_pkg::ADDR_W-1:0] awaddr_q;
  logic [tflop_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [tflop_pkg::DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic async_low;
  logic async_high;
  logic cell_q;

  // write channel decode
  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_hs);
  wire w_full_d = do_write ? 1'b0 : (w_full_q | w_hs);
  wire wr_ctrl = do_write & (awaddr_q == tflop_pkg::CTRL_OFFSET);
  wire wr_drive = do_write & (awaddr_q == tflop_pkg::DRIVE_OFFSET);
  wire wr_count = do_write & (awaddr_q == tflop_pkg::COUNT_OFFSET);
  wire wr_status = do_write & (awaddr_q == tflop_pkg::STATUS_OFFSET);
  wire wr_mapped = wr_ctrl | wr_drive | wr_count | wr_status;
  wire [tflop_pkg::CTRL_W-1:0] ctrl_wr = wstrb_q[0] ? wdata_q[tflop_pkg::CTRL_W-1:0] : ctrl_q;
  wire [tflop_pkg::DRIVE_W-1:0] drive_wr = {wstrb_q[1] ? wdata_q[8] : drive_q[8],
    wstrb_q[0] ? wdata_q[7:0] : drive_q[7:0]};

  // read channel decode
  wire ar_hs = arvalid & arready_q;
  wire rd_ctrl = (araddr == tflop_pkg::CTRL_OFFSET);
  wire rd_drive = (araddr == tflop_pkg::DRIVE_OFFSET);
  wire rd_status = (araddr == tflop_pkg::STATUS_OFFSET);
  wire rd_count = (araddr == tflop_pkg::COUNT_OFFSET);
  wire rd_mapped = rd_ctrl | rd_drive | rd_status | rd_count;

  // control source and global polarity
  wire src_regs = ctrl_q[tflop_pkg::CTRL_SRC_BIT];
  wire global_in = global_reset_net | global_set_clear_net;
  wire global_pin_active = ctrl_q[tflop_pkg::CTRL_OLDEST_BIT] ? ~global_in
    : (global_in ^ ctrl_q[tflop_pkg::CTRL_INVERT_BIT]);
  wire global_active = global_pin_active | drive_q[tflop_pkg::DRV_GLOBAL_BIT];
  wire tgl_w = src_regs ? drive_q[tflop_pkg::DRV_TOGGLE_BIT] : toggle_en;
  wire ce_w = src_regs ? drive_q[tflop_pkg::DRV_CE_BIT] : clk_en;
  wire load_w = src_regs ? drive_q[tflop_pkg::DRV_LOAD_BIT] : load_en;
  wire data_w = src_regs ? drive_q[tflop_pkg::DRV_DATA_BIT] : load_data;
  wire szero_w = src_regs ? drive_q[tflop_pkg::DRV_SZERO_BIT] : sync_zero;
  wire sone_w = src_regs ? drive_q[tflop_pkg::DRV_SONE_BIT] : sync_one;
  wire azero_w = async_zero_force | drive_q[tflop_pkg::DRV_AZERO_BIT];
  wire aone_w = async_one_force | drive_q[tflop_pkg::DRV_AONE_BIT];
  wire [3:0] variant_bits = ctrl_q[tflop_pkg::CTRL_VARIANT_LSB +: 4];
  wire tflop_pkg::variant_t variant = tflop_pkg::variant_t'(variant_bits);

  // change counter: a change in the same cycle as a clear leaves the count at one
  wire q_changed = (cell_q != q_seen_q);
  assign count_d = q_changed ? (wr_count ? 16'h0001 : count_q + 16'h0001) :
                   (wr_count ? tflop_pkg::COUNT_RESET : count_q);

  wire [tflop_pkg::DATA_W-1:0] status_word = {28'h0000000, async_high, async_low, global_active, cell_q};
  wire [tflop_pkg::DATA_W-1:0] rd_word = rd_ctrl ? {25'h0, ctrl_q} :
                                         rd_drive ? {23'h0, drive_q} :
                                         rd_status ? status_word :
                                         rd_count ? {16'h0000, count_q} : 32'h00000000;

  toggle_flop_cell u_cell
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .variant(variant),
    .toggle_en(tgl_w),
    .clk_en(ce_w),
    .load_en(load_w),
    .load_data(data_w),
    .sync_zero(szero_w),
    .sync_one(sone_w),
    .async_zero_force(azero_w),
    .async_one_force(aone_w),
    .global_active(global_active),
    .power_on_pulse_net(power_on_pulse_net),
    .async_low(async_low),
    .async_high(async_high),
    .q(cell_q)
  );

  // write path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      if (aw_hs)
        awaddr_q <= {awaddr[tflop_pkg::ADDR_W-1:2], 2'b00};
      if (w_hs)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= tflop_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? tflop_pkg::RESP_OKAY : tflop_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= tflop_pkg::CTRL_RESET;
      drive_q <= tflop_pkg::DRIVE_RESET;
      count_q <= tflop_pkg::COUNT_RESET;
      q_seen_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_wr;
      if (wr_drive)
        drive_q <= drive_wr;
      count_q <= count_d;
      q_seen_q <= cell_q;
    end
  end

  // read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= tflop_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? tflop_pkg::RESP_OKAY : tflop_pkg::RESP_SLVERR;
    end
    else if (rvalid_q & rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
    else if (!rvalid_q)
      arready_q <= 1'b1;
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign flop_q = cell_q;

  // checks
  wire quiet = ~async_low & ~async_high;
  wire sync_var = variant inside {tflop_pkg::toggle_flop_sync_zero_first,
    tflop_pkg::toggle_flop_sync_zero_first_loadable};
  wire free_load_var = variant inside {tflop_pkg::toggle_flop_async_both_loadable,
    tflop_pkg::toggle_flop_async_one_loadable};
  wire gated_var = variant inside {tflop_pkg::toggle_flop_async_both_gated,
    tflop_pkg::toggle_flop_async_one_gated};
  wire preset_var = variant inside {tflop_pkg::toggle_flop_async_one, tflop_pkg::toggle_flop_async_one_gated,
    tflop_pkg::toggle_flop_async_one_loadable};

  sequence s_toggle_edge;
    (gated_var && tgl_w && ce_w && quiet) ##1 quiet;
  endsequence

  sequence s_write_pair;
    aw_hs && w_hs && !bvalid_q;
  endsequence

  a_clear_forces_low: assert property (@(posedge aclk) disable iff (!aresetn)
    async_low |-> !cell_q) else $error("clear did not hold output low");

  a_preset_forces_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (async_high && !async_low) |-> cell_q) else $error("preset did not hold output high");

  a_clear_beats_preset: assert property (@(posedge aclk) disable iff (!aresetn)
    (azero_w && aone_w && variant == tflop_pkg::toggle_flop_async_both) |-> !cell_q)
    else $error("preset won over clear");

  a_toggle_inverts: assert property (@(posedge aclk) disable iff (!aresetn)
    s_toggle_edge |-> cell_q != $past(cell_q))
    else $error("toggle edge did not invert");

  a_disabled_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (gated_var && !ce_w && quiet) ##1 quiet |-> $stable(cell_q))
    else $error("output moved with enable low");

  a_free_load_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (free_load_var && load_w && !ce_w && quiet) ##1 quiet |-> cell_q == $past(data_w))
    else $error("load ignored with enable low");

  a_gated_load_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (variant == tflop_pkg::toggle_flop_async_zero_gated_load && load_w && ce_w && quiet) ##1 quiet
    |-> cell_q == $past(data_w)) else $error("gated load did not capture");

  a_sync_zero_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync_var && szero_w && sone_w && quiet) ##1 quiet |-> !cell_q)
    else $error("reset did not win over set");

  a_sync_one_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync_var && !szero_w && sone_w && !ce_w && quiet) ##1 quiet |-> cell_q)
    else $error("set ignored with enable low");

  a_sync_load_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (variant == tflop_pkg::toggle_flop_sync_zero_first_loadable && !szero_w && !sone_w && load_w && quiet)
    ##1 quiet |-> cell_q == $past(data_w)) else $error("synchronous load did not capture");

  a_global_preset_type: assert property (@(posedge aclk) disable iff (!aresetn)
    (global_active && preset_var && !power_on_pulse_net) |-> cell_q)
    else $error("global net did not preset");

  a_global_clear_type: assert property (@(posedge aclk) disable iff (!aresetn)
    (global_active && !preset_var) |-> !cell_q) else $error("global net did not clear");

  a_oldest_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[tflop_pkg::CTRL_OLDEST_BIT] && !global_in) |-> global_active)
    else $error("oldest mode polarity wrong");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_pair |-> ##2 bvalid_q) else $error("write response late");

  a_write_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !bready) |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped early");

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> rvalid_q) else $error("read data late");

  a_read_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_q && !rready) |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read data dropped early");

endmodule

/* File: test/tflop_user_logic.sv */
// Purpose: user logic that drives the flop's control and global pins
// Assumes: plan word is changed by the bench right after a rising edge
// Notes: pins follow the plan one edge later, like any flop in the fabric
`timescale 1ns/1ps
module tflop_user_logic
(
  // clock
  input wire logic aclk,
  // plan from bench
  input wire logic [10:0] plan,
  // user controls
  output logic toggle_en,
  output logic clk_en,
  output logic load_en,
  output logic load_data,
  output logic sync_zero,
  output logic sync_one,
  output logic async_zero_force,
  output logic async_one_force,
  // global nets
  output logic global_reset_net,
  output logic global_set_clear_net,
  output logic power_on_pulse_net
);
  always_ff @(posedge aclk)
  begin
    {async_one_force, async_zero_force, sync_one, sync_zero} <= plan[7:4];
    {load_data, load_en, clk_en, toggle_en} <= plan[3:0];
  end

  // nets idle low, so the default active-high global is inactive; power-up clear as a high pulse
  always_ff @(posedge aclk)
  begin
    {power_on_pulse_net, global_set_clear_net, global_reset_net} <= plan[10:8];
  end
endmodule

/* File: test/tb_toggle_flop_bank.sv */
// Purpose: self-checking bench for the toggle flop bank
// Assumes: bus and user pins change only just after a rising edge
// Notes: each pulse gives the flop exactly one edge with the planned pins
`timescale 1ns/1ps
module tb_toggle_flop_bank;
  localparam logic [10:0] P_T = 11'h001, P_CE = 11'h002, P_L = 11'h004, P_D = 11'h008;
  localparam logic [10:0] P_SZ = 11'h010, P_SO = 11'h020, P_CLR = 11'h040, P_PRE = 11'h080;
  localparam logic [10:0] P_GR = 11'h100, P_GSC = 11'h200, P_POR = 11'h400;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [10:0] plan = 11'h000;
  logic awready, wready, bvalid, arready, rvalid, flop_q, mq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, rd;
  logic te, ce, le, ld, sz, so, azf, aof, grn, gsc, por;
  int mismatches = 0, num_checks = 0, cycles = 0;

  always #50 aclk = ~aclk;

  tflop_user_logic user (.aclk(aclk), .plan(plan), .toggle_en(te), .clk_en(ce), .load_en(le),
    .load_data(ld), .sync_zero(sz), .sync_one(so), .async_zero_force(azf), .async_one_force(aof),
    .global_reset_net(grn), .global_set_clear_net(gsc), .power_on_pulse_net(por));

  toggle_flop_bank dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .toggle_en(te), .clk_en(ce), .load_en(le), .load_data(ld), .sync_zero(sz), .sync_one(so),
    .async_zero_force(azf), .async_one_force(aof), .global_reset_net(grn),
    .global_set_clear_net(gsc), .power_on_pulse_net(por), .flop_q(flop_q));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: flop output %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1)
      @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one edge with the planned pins; mid holds the output while pins are up
  task automatic pulse(input logic [10:0] v, output logic mid);
    @(posedge aclk);
    plan <= v;
    @(posedge aclk);
    plan <= 11'h000;
    #1 mid = flop_q;
    @(posedge aclk);
    #1;
  endtask

  task automatic mode(input tflop_pkg::variant_t v, input logic [1:0] f);
    axi_wr(tflop_pkg::CTRL_OFFSET, 32'(v) | (32'(f) << tflop_pkg::CTRL_INVERT_BIT), r);
    chk_word(32'(r), 32'(tflop_pkg::RESP_OKAY));
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1 chk_bit(flop_q, 1'b0);
    axi_rd(tflop_pkg::CTRL_OFFSET, rd);
    chk_word(rd, 32'h0000_0000);
    axi_rd(tflop_pkg::COUNT_OFFSET, rd);
    chk_word(rd, 32'h0000_0000);
    axi_wr(tflop_pkg::DRIVE_OFFSET, 32'h0000_0008, r);
    axi_rd(tflop_pkg::DRIVE_OFFSET, rd);
    chk_word(rd, 32'h0000_0008);
    mode(tflop_pkg::toggle_flop_async_both, 2'h0);
    pulse(P_T | P_CE, mq);
    chk_bit(flop_q, 1'b1);
    axi_rd(tflop_pkg::COUNT_OFFSET, rd);
    chk_word(rd, 32'h0000_0001);
    pulse(P_CLR | P_PRE, mq);
    chk_bit(mq, 1'b0);
    pulse(P_PRE, mq);
    chk_bit(mq, 1'b1);
    pulse(P_CLR | P_T, mq);
    chk_bit(mq, 1'b0);
    chk_bit(flop_q, 1'b0);
    mode(tflop_pkg::toggle_flop_async_both_gated, 2'h0);
    pulse(P_T, mq);
    chk_bit(flop_q, 1'b0);
    pulse(P_T | P_CE, mq);
    chk_bit(flop_q, 1'b1);
    mode(tflop_pkg::toggle_flop_async_both_loadable, 2'h0);
    pulse(P_L | P_T, mq);
    chk_bit(flop_q, 1'b0);
    mode(tflop_pkg::toggle_flop_async_zero_gated_load, 2'h0);
    pulse(P_L | P_D, mq);
    chk_bit(flop_q, 1'b0);
    pulse(P_L | P_D | P_CE, mq);
    chk_bit(flop_q, 1'b1);
    mode(tflop_pkg::toggle_flop_async_one_loadable, 2'h0);
    pulse(P_L, mq);
    chk_bit(flop_q, 1'b0);
    pulse(P_GR, mq);
    chk_bit(mq, 1'b1);
    mode(tflop_pkg::toggle_flop_sync_zero_first, 2'h0);
    pulse(P_SZ | P_L | P_D, mq);
    chk_bit(flop_q, 1'b0);
    pulse(P_SO | P_L, mq);
    chk_bit(flop_q, 1'b1);
    pulse(P_SZ | P_SO | P_L | P_D | P_CE | P_T, mq);
    chk_bit(flop_q, 1'b0);
    pulse(P_SO, mq);
    pulse(P_GSC, mq);
    chk_bit(mq, 1'b0);
    mode(tflop_pkg::toggle_flop_sync_zero_first_loadable, 2'h0);
    pulse(P_L | P_D, mq);
    chk_bit(flop_q, 1'b1);
    pulse(P_POR, mq);
    chk_bit(mq, 1'b0);
    mode(tflop_pkg::toggle_flop_async_one, 2'h0);
    pulse(P_POR, mq);
    mode(tflop_pkg::toggle_flop_async_one, 2'h1);
    chk_bit(flop_q, 1'b1);
    mode(tflop_pkg::toggle_flop_sync_zero_first, 2'h0);
    pulse(P_SO, mq);
    mode(tflop_pkg::toggle_flop_sync_zero_first, 2'h3);
    chk_bit(flop_q, 1'b0);
    axi_rd(tflop_pkg::STATUS_OFFSET, rd);
    chk_word(rd, 32'h0000_0006);
    chk_word(32'(r), 32'(tflop_pkg::RESP_OKAY));
    axi_wr(tflop_pkg::CTRL_OFFSET, 32'h0000_0046, r);
    axi_wr(tflop_pkg::DRIVE_OFFSET, 32'h0000_0020, r);
    pulse(11'h000, mq);
    chk_bit(flop_q, 1'b1);
    axi_wr(tflop_pkg::DRIVE_OFFSET, 32'h0000_0100, r);
    chk_bit(flop_q, 1'b0);
    final_report();
  end
endmodule
